// ==== inc/dpm_regs.svh ====
// register offsets, field layout and reset values of the dscp priority map
// Function
// - code is tos byte bits 7:2; its 2-bit entry is the priority of an ip frame.
// - register 0x91 holds codes 0x04..0x07, lowest code in bits 1-0.
// - register 0x92 holds codes 0x08..0x0B, lowest code in bits 1-0.
// - register 0x93 holds codes 0x0C..0x0F, lowest code in bits 1-0.
// - register 0x94 holds codes 0x10..0x13, lowest code in bits 1-0.
// - register 0x95 holds codes 0x14..0x17, lowest code in bits 1-0.
// - register 0x96 holds codes 0x18..0x1B, lowest code in bits 1-0.
// - register 0x97 holds codes 0x1C..0x1F, lowest code in bits 1-0.
// - register 0x98 holds codes 0x20..0x23, lowest code in bits 1-0.
// - first register 0x90 holds codes 0x00..0x03, two bits per code.
// - same pattern continues up to code 0x3F at register 0x9F.
`ifndef DPM_REGS_SVH
`define DPM_REGS_SVH
// ****************************************
// register map
// ****************************************
`define DPM_ADDR_W 8
`define DPM_BASE_OFF 8'h90
`define DPM_MAP_1_OFF 8'h91
`define DPM_MAP_2_OFF 8'h92
`define DPM_MAP_3_OFF 8'h93
`define DPM_MAP_4_OFF 8'h94
`define DPM_MAP_5_OFF 8'h95
`define DPM_MAP_6_OFF 8'h96
`define DPM_MAP_7_OFF 8'h97
`define DPM_MAP_8_OFF 8'h98
`define DPM_LAST_OFF 8'h9F
// ****************************************
// layout and reset
// ****************************************
`define DPM_NUM_REGS 16
`define DPM_ENT_PER_REG 4
`define DPM_ENT_W 2
`define DPM_CODE_LSB 2
`define DPM_CODE_MSB 7
`define DPM_REG_RESET 8'h00
`define DPM_UNMAPPED_RD 8'h00
`endif

// ==== inc/dpm_pkg.sv ====
// types of the dscp priority map
package dpm_pkg;
  typedef struct packed {
    logic valid;
    logic is_ip;
    logic [7:0] tos;
  } dpm_frame_t;
  typedef struct packed {
    logic valid;
    logic ip_hit;
    logic [1:0] prio;
  } dpm_result_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpm_bus_t;
endpackage : dpm_pkg

// ==== verilog/dpm_map.sv ====
// dscp to priority lookup table with its register port
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`include "dpm_regs.svh"
module dpm_map
  import dpm_pkg::*;
#(
  parameter int NUM_REGS = `DPM_NUM_REGS
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire dpm_bus_t bus,
  output logic [7:0] rdata_r,
  input wire dpm_frame_t frame,
  output dpm_result_t result_r
);
  // ****************************************
  // parameter checks
  // ****************************************
  if (NUM_REGS < 1 || NUM_REGS > `DPM_NUM_REGS)
  begin : g_bad_regs
    $error("NUM_REGS must lie between 1 and 16");
  end

  // ****************************************
  // table storage
  // ****************************************
  logic [7:0] map_r [NUM_REGS];
  logic [7:0] addr_rel;
  logic in_range;

  assign addr_rel = bus.addr - `DPM_BASE_OFF;
  assign in_range = (bus.addr >= `DPM_BASE_OFF) && ({1'b0, addr_rel} < 9'(NUM_REGS));

  // one byte register per four codes, each written whole
  genvar gi;
  for (gi = 0; gi < NUM_REGS; gi++)
  begin : g_map
    always_ff @(posedge sys_clk)
    begin
      if (srst)
        map_r[gi] <= `DPM_REG_RESET;
      else if (bus.wr && in_range && addr_rel == 8'(gi))
        map_r[gi] <= bus.wdata;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  // unmapped addresses read zero so software can probe safely
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rdata_r <= `DPM_UNMAPPED_RD;
    else if (bus.rd && in_range)
      rdata_r <= map_r[addr_rel[3:0]];
    else
      rdata_r <= `DPM_UNMAPPED_RD;
  end

  // ****************************************
  // lookup
  // ****************************************
  logic [5:0] code;
  logic [3:0] reg_idx;
  logic [1:0] slot;
  logic [7:0] sel_byte;
  logic [1:0] prio_nxt;

  assign code = frame.tos[`DPM_CODE_MSB:`DPM_CODE_LSB];
  assign reg_idx = code[5:2];
  assign slot = code[1:0];

  always_comb
  begin
    sel_byte = `DPM_REG_RESET;
    if (32'(reg_idx) < NUM_REGS)
      sel_byte = map_r[reg_idx];
    // lowest code of a register sits in bits 1-0
    prio_nxt = sel_byte[{slot, 1'b0} +: `DPM_ENT_W];
  end

  // non-ip frames get priority zero and no hit; another classifier decides
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      result_r <= '0;
    else
    begin
      result_r.valid <= frame.valid;
      result_r.ip_hit <= frame.valid && frame.is_ip;
      result_r.prio <= (frame.valid && frame.is_ip) ? prio_nxt : 2'h0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_ip_frame;
    frame.valid && frame.is_ip;
  endsequence

  chk_lookup_prio: assert property (@(posedge sys_clk) disable iff (srst)
    s_ip_frame |=> result_r.prio ==
      $past(map_r[frame.tos[7:4]][{frame.tos[3:2], 1'b0} +: 2]))
    else $error("priority does not match table entry");

  chk_non_ip_zero: assert property (@(posedge sys_clk) disable iff (srst)
    (frame.valid && !frame.is_ip) |=> (result_r.prio == 2'h0 && !result_r.ip_hit))
    else $error("non-ip frame got a priority");

  chk_code4_slot: assert property (@(posedge sys_clk) disable iff (srst)
    (s_ip_frame ##0 frame.tos[7:2] == 6'h04) |=> result_r.prio == $past(map_r[1][1:0]))
    else $error("code 0x04 not in low bits of second register");

  chk_code0_slot: assert property (@(posedge sys_clk) disable iff (srst)
    (s_ip_frame ##0 frame.tos[7:2] == 6'h00) |=> result_r.prio == $past(map_r[0][1:0]))
    else $error("code 0x00 not in low bits of first register");

  chk_code23_slot: assert property (@(posedge sys_clk) disable iff (srst)
    (s_ip_frame ##0 frame.tos[7:2] == 6'h23) |=> result_r.prio == $past(map_r[8][7:6]))
    else $error("code 0x23 not in top bits of register 0x98");

  chk_write_read: assert property (@(posedge sys_clk) disable iff (srst)
    (bus.wr && bus.addr == `DPM_MAP_3_OFF) ##1 (bus.rd && bus.addr == `DPM_MAP_3_OFF
      && !bus.wr) |=> rdata_r == $past(bus.wdata, 2))
    else $error("register 0x93 read back differs from write");

  chk_unmapped_rd: assert property (@(posedge sys_clk) disable iff (srst)
    (bus.rd && bus.addr < `DPM_BASE_OFF) |=> rdata_r == 8'h00)
    else $error("unmapped read not zero");

  chk_reset_zero: assert property (@(posedge sys_clk)
    $fell(srst) |-> (map_r[5] == 8'h00 && map_r[7] == 8'h00 && rdata_r == 8'h00))
    else $error("table not zero after reset");

  chk_valid_follow: assert property (@(posedge sys_clk) disable iff (srst)
    frame.valid |=> result_r.valid ##1 (result_r.valid == $past(frame.valid)))
    else $error("result valid does not follow frame");

endmodule : dpm_map

// ==== bench/dpm_map_tb.sv ====
// self-checking bench of the dscp priority map
`timescale 1ns/10ps
`include "dpm_regs.svh"
module dpm_map_tb
  import dpm_pkg::*;
;
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  dpm_bus_t bus = '0;
  dpm_frame_t frame = '0;
  logic [7:0] rdata_r;
  dpm_result_t result_r;
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] mdl [16];
  logic [31:0] seed = 32'h0000004E;

  dpm_map #(.NUM_REGS(16)) i_dpm_map (.sys_clk(sys_clk), .srst(srst), .bus(bus),
    .rdata_r(rdata_r), .frame(frame), .result_r(result_r));

  initial forever #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch rdata_r exp %h got %h", e, g);
    end
  endtask : chk_rd

  task automatic chk_res(input dpm_result_t e, input dpm_result_t g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch result_r exp %h got %h", e, g);
    end
  endtask : chk_res

  // ****************************************
  // one request cycle, idle cycle after it
  // ****************************************
  task automatic step(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
    input logic v, input logic ip, input logic [7:0] tos);
    logic [7:0] er;
    dpm_result_t eq;
    int c;
    logic hit;
    c = tos[7:2];
    hit = a >= `DPM_BASE_OFF && a <= `DPM_LAST_OFF;
    er = (r && hit) ? mdl[a - `DPM_BASE_OFF] : 8'h00;
    eq.valid = v;
    eq.ip_hit = v & ip;
    // lookup sees the table before a write in the same cycle
    eq.prio = (v & ip) ? mdl[c / 4][2 * (c % 4) +: 2] : 2'h0;
    @(posedge sys_clk);
    bus <= '{w, r, a, d};
    frame <= '{v, ip, tos};
    @(posedge sys_clk);
    bus <= '0;
    frame <= '0;
    if (w && hit) mdl[a - `DPM_BASE_OFF] = d;
    #1;
    chk_rd(er, rdata_r);
    chk_res(eq, result_r);
  endtask : step

  task automatic report_and_stop;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    for (int i = 0; i < 16; i++) mdl[i] = `DPM_REG_RESET;
    repeat (4) @(posedge sys_clk);
    srst <= 1'h0;
    for (int a = 8'h8F; a <= 8'hA0; a++)
      step(1'h0, 1'h1, 8'(a), 8'h00, 1'h0, 1'h0, 8'h00);
    for (int a = 8'h8F; a <= 8'hA0; a++)
    begin
      seed = xs(seed);
      step(1'h1, 1'h0, 8'(a), seed[7:0], 1'h1, 1'h1, seed[15:8]);
    end
    for (int a = 8'h8F; a <= 8'hA0; a++)
      step(1'h0, 1'h1, 8'(a), 8'h00, 1'h0, 1'h0, 8'h00);
    for (int c = 0; c < 64; c++)
    begin
      seed = xs(seed);
      step(1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1, {6'(c), seed[1:0]});
      step(1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h0, {6'(c), seed[3:2]});
    end
    step(1'h1, 1'h0, 8'h98, 8'hE4, 1'h0, 1'h0, 8'h00);
    step(1'h0, 1'h1, 8'h98, 8'h00, 1'h1, 1'h1, 8'h8C);
    // write then read of the same register with no gap
    @(posedge sys_clk);
    bus <= '{1'b1, 1'b0, 8'h93, 8'h5A};
    @(posedge sys_clk);
    bus <= '{1'b0, 1'b1, 8'h93, 8'h00};
    mdl[3] = 8'h5A;
    @(posedge sys_clk);
    bus <= '0;
    #1;
    chk_rd(mdl[3], rdata_r);
    // random mix, half inside the table, half at any address
    repeat (300)
    begin
      seed = xs(seed);
      step(seed[0], ~seed[0] & seed[1], seed[6] ? {4'h9, seed[5:2]} : seed[15:8],
        seed[23:16], seed[7], seed[24], seed[31:24]);
    end
    report_and_stop();
  end
endmodule : dpm_map_tb
